// >>> mblx_exec.v
// Summary of operation
// [RL1] external data address is work reg 0/1 (8 bits) or data pointer (16 bits)
// [RL2] accumulator alone sources or receives every external data byte
// [RL3] pointer constant fetch reads code at accumulator plus data pointer into accumulator
// [RL4] counter constant fetch reads code at accumulator plus next-instruction counter
// [RL5] constant fetches only read program memory, never write it
// [RL6] bit addresses 00-7f hit lower RAM bits, 80-ff hit special function space
// [RL7] each port line is a separate addressable bit
// [RL8] boolean operands use a direct bit address from the instruction only
// [RL9] status word carry is the boolean accumulator and has its own bit address
// [RL10] and, and-not, or, or-not, moves, set, clear, complement of carry or bit
// [RL11] no carry exclusive-or operation exists
// [RL12] branch on carry one, carry zero, bit one or bit zero
// [RL13] test-and-clear branch jumps on bit one and clears it at once
// [RL14] all status word bits are bit addressable and testable
// [RL15] carry to port bit drives the line high for one, low for zero
// [RL16] relative branch adds signed offset byte to counter when taken
// [RL17] branch reach is -128..+127 from the byte after the branch
// [RL18] external data moves take two machine cycles, no fetch in second
// [RL19] untaken branch falls through, changing nothing, not even the test bit
`timescale 1ns/1ps
`include "mblx_regs.vh"
module mblx_exec (
    input wire CLK_SYS,
    input wire RESETN,
    input wire OP_VALID,
    input wire [3:0] OP_CODE,
    input wire [2:0] OP_SUB,
    input wire OP_RI_SEL,
    input wire [7:0] OP_BIT_ADDR,
    input wire [7:0] OP_REL,
    input wire [7:0] ACC_IN,
    input wire [7:0] PSW_IN,
    input wire [15:0] DATA_POINTER_REG_IN,
    input wire [15:0] PC_NEXT,
    input wire [7:0] WR0_IN,
    input wire [7:0] WR1_IN,
    input wire [7:0] BIT_RD_BYTE,
    input wire [7:0] CODE_RDATA,
    input wire [7:0] XDATA_RDATA,
    output reg OP_DONE,
    output reg [7:0] ACC_OUT,
    output reg ACC_WE,
    output reg CARRY_OUT,
    output reg CARRY_WE,
    output reg [15:0] PC_OUT,
    output reg PC_WE,
    output reg [7:0] BIT_BYTE_ADDR,
    output reg BIT_RAM_SEL,
    output reg BIT_RD,
    output reg [7:0] BIT_WR_BYTE,
    output reg BIT_WE,
    output reg [15:0] CODE_ADDR,
    output reg CODE_RD,
    output reg FETCH_INHIBIT,
    output reg [15:0] XDATA_ADDR,
    output reg [7:0] XDATA_WDATA,
    output reg XDATA_RD,
    output reg XDATA_WR
);
////////////////////////////////////////////////////////////////////////////////
// reset asserts at once but leaves only after two clean edges, so no flop sees a runt
reg rst_m;
reg rst_n;
always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
        rst_m <= 1'b0;
        rst_n <= 1'b0;
    end else begin
        rst_m <= 1'b1;
        rst_n <= rst_m;
    end
end
////////////////////////////////////////////////////////////////////////////////
// one-hot states keep each state decode down to a single flop
localparam ST_IDLE = 4'h1;
localparam ST_MEM = 4'h2;
localparam ST_BITRD = 4'h4;
localparam ST_DONE = 4'h8;
reg [3:0] state;
reg [3:0] op;
reg [2:0] sub;
reg [7:0] bitaddr;
reg [7:0] rel;
reg [7:0] acc;
reg carry;
reg [15:0] pc;
// byte holding an addressed bit; carry lives in the status word by direct address too
wire [7:0] byte_addr_w = OP_BIT_ADDR[`MBLX_BIT_SFR_MSB] ?
    {OP_BIT_ADDR[7:3], 3'h0} :
    (`MBLX_RAM_BIT_BASE + {4'h0, OP_BIT_ADDR[6:3]}); // RL6 RL7 RL8 RL14
wire is_xmove = (OP_CODE[3:2] == 2'b00);
wire op_is_xwrite = (op == `MBLX_OP_XMOVE_WR_RI) || (op == `MBLX_OP_XMOVE_WR_DP);
// sign extension lets backward offsets wrap through the 16-bit counter
wire [15:0] rel_ext = {{8{rel[7]}}, rel}; // RL17
reg [7:0] cur_byte;
reg cur_bit;
reg [7:0] mask;
reg next_carry;
reg next_bit;
reg carry_wr;
reg bit_wr;
reg taken;
reg clr_bit;
always @* begin
    cur_byte = BIT_RD_BYTE;
    mask = 8'h01 << bitaddr[2:0];
    cur_bit = |(cur_byte & mask);
    next_carry = carry;
    next_bit = cur_bit;
    carry_wr = 1'b0;
    bit_wr = 1'b0;
    taken = 1'b0;
    clr_bit = 1'b0;
    // no exclusive-or code exists; software composes it
    case (op) // RL10 RL11
        `MBLX_OP_BIT_AND: begin
            next_carry = carry & cur_bit;
            carry_wr = 1'b1;
        end
        `MBLX_OP_BIT_ANDN: begin
            next_carry = carry & ~cur_bit;
            carry_wr = 1'b1;
        end
        `MBLX_OP_BIT_OR: begin
            next_carry = carry | cur_bit;
            carry_wr = 1'b1;
        end
        `MBLX_OP_BIT_ORN: begin
            next_carry = carry | ~cur_bit;
            carry_wr = 1'b1;
        end
        `MBLX_OP_BIT_CODE_CONST_FETCH: begin
            next_carry = cur_bit;
            carry_wr = 1'b1;
        end
        `MBLX_OP_BIT_MOVB: begin
            next_bit = carry; // RL15
            bit_wr = 1'b1;
        end
        `MBLX_OP_BIT_SET: begin
            next_carry = 1'b1;
            next_bit = 1'b1;
            carry_wr = (sub[0] == `MBLX_SEL_CARRY);
            bit_wr = (sub[0] != `MBLX_SEL_CARRY);
        end
        `MBLX_OP_BIT_CLR: begin
            next_carry = 1'b0;
            next_bit = 1'b0;
            carry_wr = (sub[0] == `MBLX_SEL_CARRY);
            bit_wr = (sub[0] != `MBLX_SEL_CARRY);
        end
        `MBLX_OP_BIT_CPL: begin
            next_carry = ~carry;
            next_bit = ~cur_bit;
            carry_wr = (sub[0] == `MBLX_SEL_CARRY);
            bit_wr = (sub[0] != `MBLX_SEL_CARRY);
        end
        `MBLX_OP_BRANCH: begin
            case (sub) // RL12
                `MBLX_BR_CARRY_ONE: taken = carry;
                `MBLX_BR_CARRY_ZERO: taken = ~carry;
                `MBLX_BR_BIT_ONE: taken = cur_bit;
                `MBLX_BR_BIT_ZERO: taken = ~cur_bit;
                `MBLX_BR_BIT_SET_CLR: begin
                    taken = cur_bit;
                    clr_bit = cur_bit; // RL13
                end
                default: taken = 1'b0;
            endcase
            next_bit = 1'b0;
            bit_wr = clr_bit;
        end
        default: begin
            carry_wr = 1'b0;
        end
    endcase
end
// writing the carry's own bit address also updates the carry copy
wire carry_alias = (bitaddr == `MBLX_CARRY_BITADDR); // RL9
////////////////////////////////////////////////////////////////////////////////
wire [7:0] merged_byte;
genvar gi;
generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_merge
        // only the addressed bit takes the new value, its neighbours read back unchanged
        assign merged_byte[gi] = mask[gi] ? next_bit : BIT_RD_BYTE[gi]; // RL7
    end
endgenerate
////////////////////////////////////////////////////////////////////////////////
always @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
        state <= ST_IDLE;
        op <= 4'h0;
        sub <= 3'h0;
        bitaddr <= 8'h00;
        rel <= 8'h00;
        acc <= 8'h00;
        carry <= 1'b0;
        pc <= 16'h0000;
        OP_DONE <= 1'b0;
        ACC_OUT <= 8'h00;
        ACC_WE <= 1'b0;
        CARRY_OUT <= 1'b0;
        CARRY_WE <= 1'b0;
        PC_OUT <= 16'h0000;
        PC_WE <= 1'b0;
        BIT_BYTE_ADDR <= 8'h00;
        BIT_RAM_SEL <= 1'b0;
        BIT_RD <= 1'b0;
        BIT_WR_BYTE <= 8'h00;
        BIT_WE <= 1'b0;
        CODE_ADDR <= 16'h0000;
        CODE_RD <= 1'b0;
        FETCH_INHIBIT <= 1'b0;
        XDATA_ADDR <= 16'h0000;
        XDATA_WDATA <= 8'h00;
        XDATA_RD <= 1'b0;
        XDATA_WR <= 1'b0;
    end else begin
        OP_DONE <= 1'b0;
        ACC_WE <= 1'b0;
        CARRY_WE <= 1'b0;
        PC_WE <= 1'b0;
        BIT_RD <= 1'b0;
        BIT_WE <= 1'b0;
        CODE_RD <= 1'b0;
        XDATA_RD <= 1'b0;
        XDATA_WR <= 1'b0;
        case (state)
            ST_IDLE: begin
                // inhibit drops one cycle after done, covering the whole second machine cycle
                FETCH_INHIBIT <= 1'b0;
                if (OP_VALID) begin
                    // operands are latched here; the core may change them while the op runs
                    op <= OP_CODE;
                    sub <= OP_SUB;
                    bitaddr <= OP_BIT_ADDR;
                    rel <= OP_REL;
                    acc <= ACC_IN;
                    carry <= PSW_IN[`MBLX_CARRY_POS]; // RL9
                    pc <= PC_NEXT;
                    if (is_xmove) begin
                        // second machine cycle: hold off the program fetch
                        FETCH_INHIBIT <= 1'b1; // RL18
                        XDATA_ADDR <= OP_CODE[1] ? DATA_POINTER_REG_IN :
                            {8'h00, (OP_RI_SEL ? WR1_IN : WR0_IN)}; // RL1
                        XDATA_WDATA <= ACC_IN; // RL2
                        XDATA_RD <= ~OP_CODE[0];
                        XDATA_WR <= OP_CODE[0];
                        state <= ST_MEM;
                    end else if (OP_CODE == `MBLX_OP_CFETCH_DP) begin
                        CODE_ADDR <= DATA_POINTER_REG_IN + {8'h00, ACC_IN}; // RL3
                        CODE_RD <= 1'b1; // RL5
                        state <= ST_MEM;
                    end else if (OP_CODE == `MBLX_OP_CFETCH_PC) begin
                        CODE_ADDR <= PC_NEXT + {8'h00, ACC_IN}; // RL4
                        CODE_RD <= 1'b1; // RL5
                        state <= ST_MEM;
                    end else begin
                        BIT_BYTE_ADDR <= byte_addr_w; // RL6 RL8
                        BIT_RAM_SEL <= ~OP_BIT_ADDR[`MBLX_BIT_SFR_MSB];
                        BIT_RD <= 1'b1;
                        state <= ST_BITRD;
                    end
                end
            end
            ST_MEM: begin
                // read data is valid while the strobe is high and is taken in that same cycle
                if (!op_is_xwrite) begin
                    ACC_OUT <= (op[2] ? CODE_RDATA : XDATA_RDATA); // RL2 RL3 RL4
                    ACC_WE <= 1'b1;
                end
                state <= ST_DONE;
            end
            ST_BITRD: begin
                // a carry-targeted op wins over the alias path; no op needs both
                if (carry_wr) begin
                    CARRY_OUT <= next_carry;
                    CARRY_WE <= 1'b1;
                end else if (bit_wr && carry_alias) begin
                    CARRY_OUT <= next_bit;
                    CARRY_WE <= 1'b1;
                end
                if (bit_wr) begin
                    BIT_WR_BYTE <= merged_byte; // RL7 RL15
                    BIT_WE <= 1'b1;
                end
                // untaken branch leaves the counter at the next instruction
                if (taken) begin
                    PC_OUT <= pc + rel_ext; // RL16 RL17 RL19
                    PC_WE <= 1'b1;
                end
                state <= ST_DONE;
            end
            ST_DONE: begin
                OP_DONE <= 1'b1;
                state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
        endcase
    end
end
endmodule

// >>> mblx_exec_monitor.sv
`timescale 1ns/1ps
module mblx_exec_monitor (
    input wire CLK_SYS,
    input wire RESETN,
    input wire OP_DONE,
    input wire ACC_WE,
    input wire CARRY_WE,
    input wire PC_WE,
    input wire [7:0] BIT_BYTE_ADDR,
    input wire BIT_RAM_SEL,
    input wire BIT_RD,
    input wire BIT_WE,
    input wire CODE_RD,
    input wire FETCH_INHIBIT,
    input wire XDATA_RD,
    input wire XDATA_WR
);
default clocking cb @(posedge CLK_SYS);
endclocking
default disable iff (!RESETN);
sequence xfer_start;
    XDATA_RD || XDATA_WR;
endsequence
sequence xfer_tail;
    FETCH_INHIBIT ##1 FETCH_INHIBIT ##1 (FETCH_INHIBIT && OP_DONE);
endsequence
////////////////////////////////////////////////////////////////////////////////
chk_xfer_two_cycle: assert property (xfer_start |-> xfer_tail)
    else $error("external move did not finish as two cycles with fetch held off");
chk_inhibit_hold: assert property ($rose(FETCH_INHIBIT) |-> FETCH_INHIBIT [*3])
    else $error("fetch inhibit dropped early");
chk_inhibit_cause: assert property ($rose(FETCH_INHIBIT) |-> xfer_start)
    else $error("fetch inhibit without external move");
chk_xread_acc: assert property (XDATA_RD |=> ACC_WE && !CARRY_WE)
    else $error("external read did not land in accumulator");
chk_xwrite_noacc: assert property (XDATA_WR |-> !ACC_WE [*3])
    else $error("external write touched accumulator");
chk_code_read_only: assert property (CODE_RD |-> !XDATA_WR && !BIT_WE && !FETCH_INHIBIT)
    else $error("constant fetch wrote something");
chk_code_acc: assert property (CODE_RD |=> ACC_WE)
    else $error("constant fetch missed accumulator");
chk_bit_space: assert property (BIT_RD |-> (BIT_RAM_SEL ? BIT_BYTE_ADDR[7:4] == 4'h2
    : BIT_BYTE_ADDR[7] && BIT_BYTE_ADDR[2:0] == 3'h0))
    else $error("bit byte outside its space");
chk_rmw_order: assert property (BIT_WE |-> $past(BIT_RD))
    else $error("bit write without preceding read");
chk_branch_only_pc: assert property (PC_WE |-> !ACC_WE ##1 OP_DONE)
    else $error("taken branch misbehaved");
chk_done_pulse: assert property (OP_DONE |=> !OP_DONE)
    else $error("done longer than one cycle");
endmodule
bind mblx_exec mblx_exec_monitor u_mon (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .OP_DONE(OP_DONE),
    .ACC_WE(ACC_WE), .CARRY_WE(CARRY_WE), .PC_WE(PC_WE), .BIT_BYTE_ADDR(BIT_BYTE_ADDR),
    .BIT_RAM_SEL(BIT_RAM_SEL), .BIT_RD(BIT_RD), .BIT_WE(BIT_WE), .CODE_RD(CODE_RD),
    .FETCH_INHIBIT(FETCH_INHIBIT), .XDATA_RD(XDATA_RD), .XDATA_WR(XDATA_WR));

// >>> mblx_mem_model.sv
`timescale 1ns/1ps
module mblx_mem_model (
    input wire clk,
    input wire [7:0] bit_byte_addr,
    input wire bit_we,
    input wire [7:0] bit_wr_byte,
    output wire [7:0] bit_rd_byte,
    input wire [15:0] code_addr,
    input wire code_rd,
    output wire [7:0] code_rdata,
    input wire [15:0] xdata_addr,
    input wire xdata_rd,
    input wire xdata_wr,
    input wire [7:0] xdata_wdata,
    output wire [7:0] xdata_rdata
);
reg [7:0] bmem [0:255];
reg [7:0] xmem [0:65535];
reg [7:0] code_q = 8'h00;
reg [7:0] xd_q = 8'h00;
integer i;
// fixed image so the bench can predict table reads; no write path at all
function [7:0] code_img(input [15:0] a);
    code_img = a[7:0] ^ a[15:8] ^ 8'h5a;
endfunction
initial begin
    for (i = 0; i < 65536; i = i + 1) begin
        xmem[i] = i[7:0] ^ i[15:8] ^ 8'h33;
        bmem[i[7:0]] = i[7:0] ^ 8'h6c;
    end
end
assign bit_rd_byte = bmem[bit_byte_addr];
// data valid while the strobe is high and held one cycle after, then toggles so stale reads show
assign code_rdata = code_rd ? code_img(code_addr) : code_q;
assign xdata_rdata = xdata_rd ? xmem[xdata_addr] : xd_q;
always @(posedge clk) begin
    code_q <= code_rd ? code_img(code_addr) : ~code_q;
    xd_q <= xdata_rd ? xmem[xdata_addr] : ~xd_q;
    if (xdata_wr)
        xmem[xdata_addr] <= xdata_wdata;
    if (bit_we)
        bmem[bit_byte_addr] <= bit_wr_byte;
end
endmodule

// >>> mblx_regs.vh
`ifndef MBLX_REGS_VH
`define MBLX_REGS_VH
// operation codes presented on OP_CODE
`define MBLX_OP_XMOVE_RD_RI 4'h0
`define MBLX_OP_XMOVE_WR_RI 4'h1
`define MBLX_OP_XMOVE_RD_DP 4'h2
`define MBLX_OP_XMOVE_WR_DP 4'h3
`define MBLX_OP_CFETCH_DP 4'h4
`define MBLX_OP_CFETCH_PC 4'h5
`define MBLX_OP_BIT_AND 4'h6
`define MBLX_OP_BIT_ANDN 4'h7
`define MBLX_OP_BIT_OR 4'h8
`define MBLX_OP_BIT_ORN 4'h9
`define MBLX_OP_BIT_CODE_CONST_FETCH 4'ha
`define MBLX_OP_BIT_MOVB 4'hb
`define MBLX_OP_BIT_SET 4'hc
`define MBLX_OP_BIT_CLR 4'hd
`define MBLX_OP_BIT_CPL 4'he
`define MBLX_OP_BRANCH 4'hf
// sub-select for set/clear/complement: target is carry or bit
`define MBLX_SEL_CARRY 1'b1
// branch conditions on OP_SUB
`define MBLX_BR_CARRY_ONE 3'h0
`define MBLX_BR_CARRY_ZERO 3'h1
`define MBLX_BR_BIT_ONE 3'h2
`define MBLX_BR_BIT_ZERO 3'h3
`define MBLX_BR_BIT_SET_CLR 3'h4
// bit address space split
`define MBLX_BIT_SFR_MSB 7
`define MBLX_RAM_BIT_BASE 8'h20
// carry bit address inside status word, and its position
`define MBLX_CARRY_BITADDR 8'hd7
`define MBLX_CARRY_POS 7
`endif

// >>> mblx_tb.sv
`timescale 1ns/1ps
`include "mblx_regs.vh"
module testbench;
reg clk = 1'b0;
reg rst_n = 1'b0;
reg vld = 1'b0;
reg [3:0] op = 4'h0;
reg [2:0] sub = 3'h0;
reg ri = 1'b0;
reg [7:0] ba = 8'h00, rel = 8'h00, acc = 8'h00, program_status_word = 8'h00, wr0 = 8'h00, wr1 = 8'h00;
reg [15:0] data_pointer_reg = 16'h0000, pcn = 16'h0000, xaddr;
wire [7:0] brd, crd, xrd, acc_o, bba, bwr, xwd;
wire [15:0] pc_o, ca, xa;
wire done, acc_we, c_o, c_we, pc_we, ram_sel, b_rd, b_we, c_rd, inh, x_rd, x_wr;
integer n_mismatch = 0, n_compared = 0, n;
reg [31:0] seed = 32'hb8ee336e;
reg [8:0] a_v;
reg [1:0] c_v;
reg [16:0] p_v;
reg [7:0] bo, byt, eb;
reg b, nb, nc, tk;
always #5 clk = ~clk;
mblx_exec dut (.CLK_SYS(clk), .RESETN(rst_n), .OP_VALID(vld), .OP_CODE(op), .OP_SUB(sub),
    .OP_RI_SEL(ri), .OP_BIT_ADDR(ba), .OP_REL(rel), .ACC_IN(acc), .PSW_IN(program_status_word), .DATA_POINTER_REG_IN(data_pointer_reg),
    .PC_NEXT(pcn), .WR0_IN(wr0), .WR1_IN(wr1), .BIT_RD_BYTE(brd), .CODE_RDATA(crd),
    .XDATA_RDATA(xrd), .OP_DONE(done), .ACC_OUT(acc_o), .ACC_WE(acc_we), .CARRY_OUT(c_o),
    .CARRY_WE(c_we), .PC_OUT(pc_o), .PC_WE(pc_we), .BIT_BYTE_ADDR(bba), .BIT_RAM_SEL(ram_sel),
    .BIT_RD(b_rd), .BIT_WR_BYTE(bwr), .BIT_WE(b_we), .CODE_ADDR(ca), .CODE_RD(c_rd),
    .FETCH_INHIBIT(inh), .XDATA_ADDR(xa), .XDATA_WDATA(xwd), .XDATA_RD(x_rd), .XDATA_WR(x_wr));
mblx_mem_model mem (.clk(clk), .bit_byte_addr(bba), .bit_we(b_we), .bit_wr_byte(bwr),
    .bit_rd_byte(brd), .code_addr(ca), .code_rd(c_rd), .code_rdata(crd), .xdata_addr(xa),
    .xdata_rd(x_rd), .xdata_wr(x_wr), .xdata_wdata(xwd), .xdata_rdata(xrd));
////////////////////////////////////////////////////////////////////////////////
function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
endfunction
task end_sim;
    begin
        if (n_mismatch == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
endtask
task chk(input string what, input [16:0] exp, input [16:0] got);
    begin
        n_compared = n_compared + 1;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            n_mismatch = n_mismatch + 1;
        end
    end
endtask
// write pulses are caught mid-cycle where they have settled
always @(negedge clk) begin
    if (acc_we === 1'b1)
        a_v = {1'b1, acc_o};
    if (c_we === 1'b1)
        c_v = {1'b1, c_o};
    if (pc_we === 1'b1)
        p_v = {1'b1, pc_o};
end
task run;
    integer k;
    begin
        a_v = 9'h000;
        c_v = 2'b00;
        p_v = 17'h00000;
        vld = 1'b1;
        @(posedge clk) #1;
        vld = 1'b0;
        for (k = 0; k < 8 && done !== 1'b1; k = k + 1)
            @(posedge clk) #1;
        chk("op_done", 17'h1, {16'h0, done});
        @(posedge clk) #1;
    end
endtask
initial begin
    #100000;
    n_mismatch = n_mismatch + 1;
    end_sim;
end
initial begin
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    for (n = 0; n < 320; n = n + 1) begin
        repeat (32) seed = lfsr(seed);
        {acc, program_status_word, wr0, wr1} = seed;
        repeat (32) seed = lfsr(seed);
        {data_pointer_reg, pcn} = seed;
        repeat (32) seed = lfsr(seed);
        {ba, rel, ri, sub} = seed[19:0];
        op = n[3:0];
        if (n < 32) begin
            acc = 8'h00;
            rel = n[4] ? 8'h7f : 8'h80;
        end
        if (op == `MBLX_OP_BRANCH)
            sub = seed[31:29] % 3'd5;
        // the carry's own bit address is kept out: its byte image is not the sampled carry
        if (ba == `MBLX_CARRY_BITADDR)
            ba = 8'hd6;
        // corner: set and clear reaching the carry through its own bit address
        if (n >= 32 && n < 64 && (op == `MBLX_OP_BIT_SET || op == `MBLX_OP_BIT_CLR)) begin
            ba = `MBLX_CARRY_BITADDR;
            sub[0] = n[4];
        end
        byt = ba[7] ? {ba[7:3], 3'b000} : `MBLX_RAM_BIT_BASE + ba[6:3];
        bo = mem.bmem[byt];
        b = bo[ba[2:0]];
        xaddr = op[1] ? data_pointer_reg : {8'h00, ri ? wr1 : wr0};
        nc = program_status_word[7];
        nb = b;
        tk = 1'b0;
        case (op)
            `MBLX_OP_BIT_AND: nc = program_status_word[7] & b;
            `MBLX_OP_BIT_ANDN: nc = program_status_word[7] & ~b;
            `MBLX_OP_BIT_OR: nc = program_status_word[7] | b;
            `MBLX_OP_BIT_ORN: nc = program_status_word[7] | ~b;
            `MBLX_OP_BIT_CODE_CONST_FETCH: nc = b;
            `MBLX_OP_BIT_MOVB: nb = program_status_word[7];
            `MBLX_OP_BIT_SET, `MBLX_OP_BIT_CLR, `MBLX_OP_BIT_CPL: begin
                if (sub[0] == `MBLX_SEL_CARRY)
                    nc = (op == `MBLX_OP_BIT_SET) | ((op == `MBLX_OP_BIT_CPL) & ~program_status_word[7]);
                else
                    nb = (op == `MBLX_OP_BIT_SET) | ((op == `MBLX_OP_BIT_CPL) & ~b);
            end
            `MBLX_OP_BRANCH: begin
                tk = (sub == 3'h4 || sub[1]) ? b ^ sub[0] : program_status_word[7] ^ sub[0];
                if (sub == `MBLX_BR_BIT_SET_CLR)
                    nb = 1'b0;
            end
            default: nc = program_status_word[7];
        endcase
        if (ba == `MBLX_CARRY_BITADDR && sub[0] != `MBLX_SEL_CARRY)
            nc = nb;
        run;
        if (op < `MBLX_OP_CFETCH_DP) begin
            chk("xdata_addr", {1'b0, xaddr}, {1'b0, xa});
            chk("acc", op[0] ? 17'h0 : {8'h01, mem.xmem[xaddr]}, {8'h0, a_v});
            if (op[0])
                chk("xdata_mem", {9'h0, acc}, {9'h0, mem.xmem[xaddr]});
        end else if (op < `MBLX_OP_BIT_AND) begin
            xaddr = (op[0] ? pcn : data_pointer_reg) + {8'h00, acc};
            chk("code_addr", {1'b0, xaddr}, {1'b0, ca});
            chk("acc", {8'h01, mem.code_img(xaddr)}, {8'h0, a_v});
        end else begin
            chk("carry", {16'h0, nc}, {16'h0, c_v[1] ? c_v[0] : program_status_word[7]});
            eb = bo;
            eb[ba[2:0]] = nb;
            chk("bit_byte", {9'h0, eb}, {9'h0, mem.bmem[byt]});
            chk("bit_ram_sel", {16'h0, ~ba[7]}, {16'h0, ram_sel});
            chk("pc", tk ? {1'b1, pcn + {{8{rel[7]}}, rel}} : 17'h0, p_v);
            if (op < `MBLX_OP_BIT_SET)
                chk("bit_addr", {9'h0, byt}, {9'h0, bba});
        end
    end
    end_sim;
end
endmodule
